// [hdl/conv_sequencer.sv]
// Conversion sequencer for a 10-bit successive approximation converter.
// Assumes a 20 MHz clock, a strobe register port, and an analog front end that
// answers a comparison within one converter clock half cycle.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns

module conv_sequencer (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       clock_enable,
  input  wire logic [2:0] address,
  input  wire logic [7:0] write_data,
  input  wire logic       write_strobe,
  input  wire logic       read_strobe,
  output logic      [7:0] read_data,
  input  wire logic [7:0] trigger_inputs,
  input  wire logic       compare_high,
  output logic            sample_hold,
  output logic      [9:0] trial_code,
  output logic      [4:0] channel_select,
  output logic      [1:0] reference_select,
  output logic            converting
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] input_select_register;
  logic [7:0] converter_control_b;
  logic       converter_enable;
  logic       start_conversion;
  logic       auto_trigger_enable;
  logic       conversion_done_flag;
  logic [2:0] prescaler_select;
  logic [9:0] result;
  logic       result_locked;

  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_wait  = 4'b0010,
    st_run   = 4'b0100,
    st_done  = 4'b1000
  } state_t;

  state_t     state;
  logic [5:0] half_count;
  logic [5:0] length;
  logic [5:0] hold_at;
  logic       first_pending;
  logic       auto_started;
  logic       self_restart;
  logic       cc_phase;
  logic [1:0] trig_sync;
  logic       trig_prev;
  logic [1:0] trig_delay;
  logic       trig_pulse;
  logic       half_tick;
  logic       rise_tick;
  logic       prescale_hold;
  logic       sar_load;
  logic       sar_finished;
  logic [9:0] sar_trial;
  logic       complete;
  logic       start_write;
  logic       read_low;
  logic       read_high;
  logic       level;
  logic       self_source;
  logic       differential;
  logic       lock_select;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  always_comb begin
    start_write = write_strobe && address == conv_seq_pkg::converter_control_a_addr
                  && write_data[conv_seq_pkg::ctl_start];
    read_low    = read_strobe && address == conv_seq_pkg::result_low_byte_addr;
    read_high   = read_strobe && address == conv_seq_pkg::result_high_byte_addr;
    level       = trigger_inputs[converter_control_b[conv_seq_pkg::ctlb_source_lsb +: 3]];
    self_source = converter_control_b[conv_seq_pkg::ctlb_source_lsb +: 3]
                  == conv_seq_pkg::source_self;
    differential = input_select_register[conv_seq_pkg::sel_differential];
    complete    = state == st_run && half_tick && half_count == length;
    // Trigger sync pipeline ends in a prescaler reset, so the hold is one cycle
    prescale_hold = !converter_enable || trig_pulse;
    lock_select = state == st_run && half_count < length - 6'h02;
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      input_select_register <= conv_seq_pkg::input_select_reset;
      converter_control_b   <= conv_seq_pkg::control_b_reset;
      converter_enable      <= 1'b0;
      auto_trigger_enable   <= 1'b0;
      prescaler_select      <= 3'h0;
    end else if (clock_enable && write_strobe) begin
      unique case (address)
        conv_seq_pkg::input_select_register_addr: input_select_register <= write_data;
        conv_seq_pkg::converter_control_b_addr:   converter_control_b   <= write_data;
        conv_seq_pkg::converter_control_a_addr: begin
          converter_enable    <= write_data[conv_seq_pkg::ctl_enable];
          auto_trigger_enable <= write_data[conv_seq_pkg::ctl_auto];
          prescaler_select    <= write_data[conv_seq_pkg::ctl_prescale_lsb +: 3];
        end
        default: ;
      endcase
    end
  end

  // Selection buffer: follows the register only while enabled and unlocked
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      channel_select   <= 5'h00;
      reference_select <= 2'h0;
    end else if (clock_enable && converter_enable && !lock_select) begin
      channel_select   <= input_select_register[4:0];
      reference_select <= input_select_register[conv_seq_pkg::sel_reference_lsb +: 2];
    end
  end

  // ---------------------------------------------------------------
  // Trigger edge detection and sync delay
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      trig_sync  <= 2'h0;
      trig_prev  <= 1'b0;
      trig_delay <= 2'h0;
      trig_pulse <= 1'b0;
    end else if (clock_enable) begin
      trig_sync  <= {trig_sync[0], level};
      trig_prev  <= trig_sync[1];
      // Three cycles from sampled edge to prescaler reset
      trig_delay <= {trig_delay[0], trig_sync[1] && !trig_prev};
      trig_pulse <= trig_delay[1] && auto_trigger_enable && !self_source
                    && converter_enable && state == st_idle;
    end
  end

  conv_prescaler u_prescaler (
    .clock            (clock),
    .sys_rst          (sys_rst),
    .clock_enable     (clock_enable),
    .hold             (prescale_hold),
    .prescaler_select (prescaler_select),
    .half_tick        (half_tick),
    .rise_tick        (rise_tick)
  );

  conv_sar u_sar (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .clock_enable (clock_enable),
    .load         (sar_load),
    .step         (half_tick && state == st_run && half_count > hold_at && !half_count[0]),
    .compare_high (compare_high),
    .trial        (sar_trial),
    .finished     (sar_finished)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state            <= st_idle;
      half_count       <= 6'h00;
      length           <= conv_seq_pkg::normal_half_cycles;
      hold_at          <= conv_seq_pkg::normal_hold_half;
      first_pending    <= 1'b1;
      auto_started     <= 1'b0;
      self_restart     <= 1'b0;
      start_conversion <= 1'b0;
      cc_phase         <= 1'b0;
      sar_load         <= 1'b0;
    end else if (clock_enable) begin
      sar_load <= 1'b0;
      if (rise_tick) begin
        cc_phase <= !cc_phase;
      end
      // A write that sets enable and start together must not lose the start
      if (!converter_enable && !(start_write && write_data[conv_seq_pkg::ctl_enable])) begin
        state            <= st_idle;
        first_pending    <= 1'b1;
        start_conversion <= 1'b0;
        cc_phase         <= 1'b0;
      end else begin
        unique case (state)
          st_idle: begin
            if (start_write) begin
              start_conversion <= 1'b1;
              auto_started     <= 1'b0;
              state            <= st_wait;
            end else if (trig_pulse) begin
              start_conversion <= 1'b1;
              auto_started     <= 1'b1;
              state            <= st_wait;
            end
          end
          st_wait: begin
            // Begins on the next converter clock rising edge, or for a manual or free running differential start the next one with cc_phase low
            if (rise_tick && !(differential && cc_phase && !auto_started)) begin
              state      <= st_run;
              half_count <= 6'h01;
              sar_load   <= 1'b1;
              if (first_pending) begin
                length  <= conv_seq_pkg::first_half_cycles;
                hold_at <= conv_seq_pkg::first_hold_half;
              end else if (auto_started) begin
                length  <= conv_seq_pkg::auto_half_cycles;
                hold_at <= conv_seq_pkg::auto_hold_half;
              end else if (differential && self_restart) begin
                length  <= conv_seq_pkg::diff_half_cycles;
                hold_at <= conv_seq_pkg::normal_hold_half;
              end else begin
                length  <= conv_seq_pkg::normal_half_cycles;
                hold_at <= conv_seq_pkg::normal_hold_half;
              end
              first_pending <= 1'b0;
            end
          end
          st_run: begin
            if (half_tick) begin
              half_count <= half_count + 6'h01;
            end
            if (complete) begin
              state <= st_done;
            end
          end
          st_done: begin
            // Free running restarts at once with start still high
            if (auto_trigger_enable && self_source) begin
              self_restart <= 1'b1;
              auto_started <= 1'b0;
              state        <= st_wait;
            end else begin
              self_restart     <= 1'b0;
              start_conversion <= 1'b0;
              state            <= st_idle;
            end
          end
          default: state <= st_idle;
        endcase
      end
    end
  end

  // Sample-and-hold pulse at the chosen half cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sample_hold <= 1'b0;
    end else if (clock_enable) begin
      sample_hold <= state == st_run && half_tick && half_count == hold_at;
    end
  end

  // ---------------------------------------------------------------
  // Result, lock and done flag
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      result        <= 10'h000;
      result_locked <= 1'b0;
    end else if (clock_enable) begin
      if (state == st_done && !result_locked) begin
        result <= sar_trial;
      end
      if (read_low) begin
        result_locked <= 1'b1;
      end else if (read_high) begin
        result_locked <= 1'b0;
      end
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      conversion_done_flag <= 1'b0;
    end else if (clock_enable) begin
      if (state == st_done) begin
        conversion_done_flag <= 1'b1;
      end else if (write_strobe && address == conv_seq_pkg::converter_control_a_addr
                   && write_data[conv_seq_pkg::ctl_done_flag]) begin
        conversion_done_flag <= 1'b0;
      end
    end
  end

  function automatic logic [15:0] align(input logic [9:0] value, input logic left);
    align = left ? {value, 6'h00} : {6'h00, value};
  endfunction

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      read_data <= 8'h00;
    end else if (clock_enable) begin
      read_data <= 8'h00;
      if (read_strobe) begin
        unique case (address)
          conv_seq_pkg::input_select_register_addr: read_data <= input_select_register;
          conv_seq_pkg::converter_control_b_addr:   read_data <= converter_control_b;
          conv_seq_pkg::converter_control_a_addr:
            read_data <= {converter_enable, start_conversion, auto_trigger_enable,
                          conversion_done_flag, 1'b0, prescaler_select};
          conv_seq_pkg::result_low_byte_addr:
            read_data <= align(result,
                         input_select_register[conv_seq_pkg::sel_left_adjust])[7:0];
          conv_seq_pkg::result_high_byte_addr:
            read_data <= align(result,
                         input_select_register[conv_seq_pkg::sel_left_adjust])[15:8];
          default: read_data <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      trial_code <= 10'h000;
      converting <= 1'b0;
    end else if (clock_enable) begin
      trial_code <= sar_trial;
      converting <= state == st_run && !sar_finished;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_done_sets_flag: assert property (@(posedge clock) disable iff (sys_rst)
    clock_enable && state == st_done |=> conversion_done_flag)
    else $error("done flag not set at completion");

  a_lock_holds_result: assert property (@(posedge clock) disable iff (sys_rst)
    result_locked && !read_high |=> $stable(result))
    else $error("locked result changed");

  a_start_high_busy: assert property (@(posedge clock) disable iff (sys_rst)
    state == st_run |-> start_conversion)
    else $error("start bit low during conversion");

  a_single_clears_start: assert property (@(posedge clock) disable iff (sys_rst)
    clock_enable && state == st_done && !auto_trigger_enable && converter_enable
    |=> !start_conversion)
    else $error("start bit not cleared in single mode");

  a_disabled_idle: assert property (@(posedge clock) disable iff (sys_rst)
    clock_enable && !converter_enable
    |-> !half_tick ##1 (state == st_idle || converter_enable))
    else $error("activity while disabled");

  a_no_trigger_busy: assert property (@(posedge clock) disable iff (sys_rst)
    state != st_idle |-> !trig_pulse)
    else $error("trigger accepted during conversion");

  a_free_run_restart: assert property (@(posedge clock) disable iff (sys_rst)
    clock_enable && state == st_done && converter_enable && auto_trigger_enable
    && self_source |=> state == st_wait && start_conversion)
    else $error("free running did not restart");

  a_select_locked: assert property (@(posedge clock) disable iff (sys_rst)
    clock_enable && lock_select && $past(lock_select) |-> $stable(channel_select))
    else $error("channel changed mid conversion");

endmodule

// [hdl/conv_seq_pkg.sv]
// Shared constants for the conversion sequencer: register offsets, field positions,
// reset values and conversion timing counts.
// Assumes a 20 MHz system clock and the plain strobe register port.
package conv_seq_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] input_select_register_addr = 3'h0;
  localparam logic [2:0] converter_control_a_addr   = 3'h1;
  localparam logic [2:0] converter_control_b_addr   = 3'h2;
  localparam logic [2:0] result_low_byte_addr       = 3'h3;
  localparam logic [2:0] result_high_byte_addr      = 3'h4;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int sel_reference_lsb = 6;
  localparam int sel_left_adjust   = 5;
  localparam int sel_differential  = 4;
  localparam int ctl_enable        = 7;
  localparam int ctl_start         = 6;
  localparam int ctl_auto          = 5;
  localparam int ctl_done_flag     = 4;
  localparam int ctl_prescale_lsb  = 0;
  localparam int ctlb_source_lsb   = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] input_select_reset = 8'h00;
  localparam logic [7:0] control_a_reset    = 8'h00;
  localparam logic [7:0] control_b_reset    = 8'h00;

  // ---------------------------------------------------------------
  // Timing, in converter clock half cycles; trigger_sync_cycles in system clock cycles
  // ---------------------------------------------------------------
  localparam logic [5:0] normal_half_cycles = 6'h1a;  // 13 cycles
  localparam logic [5:0] first_half_cycles  = 6'h32;  // 25 cycles
  localparam logic [5:0] diff_half_cycles   = 6'h1c;  // 14 cycles
  localparam logic [5:0] auto_half_cycles   = 6'h1b;  // 13.5 cycles
  localparam logic [5:0] normal_hold_half   = 6'h03;  // 1.5 cycles
  localparam logic [5:0] first_hold_half    = 6'h1b;  // 13.5 cycles
  localparam logic [5:0] auto_hold_half     = 6'h04;  // 2 cycles
  localparam logic [5:0] diff_extra_half    = 6'h02;  // 1 cycle phase wait
  localparam int         trigger_sync_cycles = 3;

  // Trigger source code that selects the converter's own done flag
  localparam logic [2:0] source_self = 3'h0;

endpackage

// [hdl/conv_prescaler.sv]
// Converter clock prescaler: divides the system clock by a selectable power of two.
// Assumes one system clock; the tick outputs are single-cycle enables, not clocks.
`timescale 1ns/1ns
module conv_prescaler #(
  parameter int width = 7
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       clock_enable,
  input  wire logic       hold,
  input  wire logic [2:0] prescaler_select,
  output logic            half_tick,
  output logic            rise_tick
);
  logic [width-1:0] count;
  logic [width-1:0] half_mask;

  // Divide ratio 2^(select+1); a half tick marks each converter clock edge
  always_comb begin
    half_mask = width'((1 << prescaler_select) - 1);
  end

  always_ff @(posedge clock) begin
    if (sys_rst || hold) begin
      count <= '0;
    end else if (clock_enable) begin
      count <= count + width'(1);
    end
  end

  always_comb begin
    half_tick = clock_enable && !hold && ((count & half_mask) == half_mask);
    rise_tick = half_tick && !count[prescaler_select];
  end

endmodule

// [hdl/conv_sar.sv]
// Successive approximation register: one bit decided per step, MSB first.
// Assumes the comparator answer is already synchronised to the system clock.
`timescale 1ns/1ns
module conv_sar #(
  parameter int bits = 10
) (
  input  wire logic            clock,
  input  wire logic            sys_rst,
  input  wire logic            clock_enable,
  input  wire logic            load,
  input  wire logic            step,
  input  wire logic            compare_high,
  output logic [bits-1:0]      trial,
  output logic                 finished
);
  logic [bits-1:0] bit_mask;

  // Code 0 is ground; all ones is reference minus one step
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      trial    <= '0;
      bit_mask <= '0;
      finished <= 1'b0;
    end else if (clock_enable) begin
      if (load) begin
        trial    <= {1'b1, {(bits-1){1'b0}}};
        bit_mask <= {1'b1, {(bits-1){1'b0}}};
        finished <= 1'b0;
      end else if (step && bit_mask != '0) begin
        if (compare_high) begin
          trial <= (trial & ~bit_mask) | (bit_mask >> 1);
        end else begin
          trial <= trial | (bit_mask >> 1);
        end
        bit_mask <= bit_mask >> 1;
        finished <= (bit_mask == {{(bits-1){1'b0}}, 1'b1});
      end
    end
  end

endmodule

// [verification/analog_front_end.sv]
// Behavioural model of the analog sample-and-hold and comparator front end.
// Assumes the sequencer pulses sample_hold once per conversion and steps trial_code.
`timescale 1ns/1ns
module analog_front_end (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       sample_hold,
  input  wire logic [9:0] trial_code,
  input  wire logic [9:0] level,
  output logic            compare_high
);
  logic [9:0] held;
  // ---------------------------------------------------------------
  // Hold capacitor
  // ---------------------------------------------------------------
  // Input may move after the pulse; after the pulse cycle only the held value is compared
  always_ff @(posedge clock) begin
    if (sys_rst) held <= 10'h000;
    else if (sample_hold) held <= level;
  end
  // Trial above the held input means that bit must be dropped
  // At prescaler 0 with an odd hold half cycle the first step falls in the hold pulse cycle, so the input is seen directly then
  assign compare_high = (trial_code > (sample_hold ? level : held));
endmodule

// [verification/conv_sequencer_tb.sv]
// Self-checking bench for the conversion sequencer over its strobe register port.
// Assumes the analog model answers within one converter half cycle.
`timescale 1ns/1ns
`define check(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); n_errors++; end end
module conv_sequencer_tb;
  logic       clock, sys_rst, write_strobe, read_strobe, compare_high, sample_hold, converting;
  logic [2:0] address;
  logic [7:0] write_data, read_data, trigger_inputs, d;
  logic [9:0] trial_code, level;
  logic [4:0] channel_select;
  logic [1:0] reference_select;
  int         n_errors, n_tests, cycles, k;
  conv_sequencer u_conv_sequencer (.clock(clock), .sys_rst(sys_rst), .clock_enable(1'b1),
    .address(address), .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data), .trigger_inputs(trigger_inputs),
    .compare_high(compare_high), .sample_hold(sample_hold), .trial_code(trial_code),
    .channel_select(channel_select), .reference_select(reference_select),
    .converting(converting));
  analog_front_end u_analog_front_end (.clock(clock), .sys_rst(sys_rst),
    .sample_hold(sample_hold), .trial_code(trial_code), .level(level),
    .compare_high(compare_high));
  // ---------------------------------------------------------------
  // Register port tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clock) begin address <= a; write_data <= v; write_strobe <= 1'b1; end
    @(posedge clock) write_strobe <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [2:0] a);
    @(posedge clock) begin address <= a; read_strobe <= 1'b1; end
    @(posedge clock) read_strobe <= 1'b0;
    #1 d = read_data;
  endtask
  task automatic wait_idle;
    for (k = 0; k < 400; k++) begin
      rd(conv_seq_pkg::converter_control_a_addr);
      if (d[conv_seq_pkg::ctl_start] === 1'b0) break;
    end
    if (k == 400) n_errors++;
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (cycles > 30000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    sys_rst = 1'b1; write_strobe = 1'b0; read_strobe = 1'b0; address = 3'h0;
    write_data = 8'h00; trigger_inputs = 8'h00; level = 10'h2a5;
    n_errors = 0; n_tests = 0; cycles = 0;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    rd(conv_seq_pkg::converter_control_a_addr);
    `check("ctrl_a reset", conv_seq_pkg::control_a_reset, d)
    rd(3'h6);
    `check("unmapped read", 8'h00, d)
    wr(conv_seq_pkg::input_select_register_addr, 8'h43);
    repeat (3) @(posedge clock);
    `check("channel before enable", 5'h00, channel_select)
    wr(conv_seq_pkg::converter_control_a_addr, 8'hc0);
    rd(conv_seq_pkg::converter_control_a_addr);
    `check("start held", 1'b1, d[conv_seq_pkg::ctl_start])
    `check("channel after enable", 5'h03, channel_select)
    `check("reference after enable", 2'h1, reference_select)
    wait_idle();
    `check("done flag", 1'b1, d[conv_seq_pkg::ctl_done_flag])
    rd(conv_seq_pkg::result_low_byte_addr);
    `check("low right", 8'ha5, d)
    rd(conv_seq_pkg::result_high_byte_addr);
    `check("high right", 8'h02, d)
    // Locked result: a conversion finishing between low and high reads is lost
    level = 10'h15a;
    rd(conv_seq_pkg::result_low_byte_addr);
    wr(conv_seq_pkg::converter_control_a_addr, 8'hd0);
    wait_idle();
    `check("flag while locked", 1'b1, d[conv_seq_pkg::ctl_done_flag])
    rd(conv_seq_pkg::result_high_byte_addr);
    `check("high kept", 8'h02, d)
    rd(conv_seq_pkg::result_low_byte_addr);
    `check("low kept", 8'ha5, d)
    rd(conv_seq_pkg::result_high_byte_addr);
    wr(conv_seq_pkg::input_select_register_addr, 8'h63);
    wr(conv_seq_pkg::converter_control_a_addr, 8'hd0);
    wait_idle();
    rd(conv_seq_pkg::result_low_byte_addr);
    `check("low left", 8'h80, d)
    rd(conv_seq_pkg::result_high_byte_addr);
    `check("high left", 8'h56, d)
    // Free running on its own flag: start stays high across completions
    wr(conv_seq_pkg::converter_control_b_addr, 8'h00);
    wr(conv_seq_pkg::converter_control_a_addr, 8'hf0);
    repeat (200) @(posedge clock);
    rd(conv_seq_pkg::converter_control_a_addr);
    `check("free run flag", 1'b1, d[conv_seq_pkg::ctl_done_flag])
    `check("free run start", 1'b1, d[conv_seq_pkg::ctl_start])
    wr(conv_seq_pkg::converter_control_a_addr, 8'h90);
    wait_idle();
    // Trigger edge starts one conversion; a held trigger starts no other
    wr(conv_seq_pkg::converter_control_b_addr, 8'h01);
    wr(conv_seq_pkg::converter_control_a_addr, 8'hb0);
    repeat (4) @(posedge clock);
    `check("no edge idle", 1'b0, converting)
    @(posedge clock) trigger_inputs <= 8'h02;
    repeat (12) @(posedge clock);
    `check("trigger start", 1'b1, converting)
    wait_idle();
    `check("trigger done", 1'b0, d[conv_seq_pkg::ctl_start])
    repeat (40) @(posedge clock);
    `check("held trigger", 1'b0, converting)
    // Trigger dropped before the next event; enable cycled for a differential run
    @(posedge clock) trigger_inputs <= 8'h00;
    wr(conv_seq_pkg::input_select_register_addr, 8'h13);
    wr(conv_seq_pkg::converter_control_a_addr, 8'h30);
    wr(conv_seq_pkg::converter_control_a_addr, 8'hb0);
    repeat (4) @(posedge clock);
    @(posedge clock) trigger_inputs <= 8'h02;
    repeat (12) @(posedge clock);
    `check("second trigger", 1'b1, converting)
    wait_idle();
    `check("second done", 1'b0, d[conv_seq_pkg::ctl_start])
    finish_test();
  end
endmodule
